// ### inc/tsf_pkg.sv
// Purpose: constants for the transceiver status and byte queue register group
// Assumes: APB byte address is four times the register index
// Notes: indices E9..EB fixed, F0..F5 local additions
package tsf_pkg;
    localparam int unsigned TSF_AW    = 12;
    localparam int unsigned TSF_DEPTH = 64;
    localparam int unsigned TSF_GW    = 8;

    localparam logic [7:0] TSF_IDX_STATUS2 = 8'hE9;
    localparam logic [7:0] TSF_IDX_DATA    = 8'hEA;
    localparam logic [7:0] TSF_IDX_LEVEL   = 8'hEB;
    localparam logic [7:0] TSF_IDX_CTRL    = 8'hF0;
    localparam logic [7:0] TSF_IDX_TXGUARD = 8'hF1;
    localparam logic [7:0] TSF_IDX_RXGUARD = 8'hF2;
    localparam logic [7:0] TSF_IDX_IRQSTS  = 8'hF3;
    localparam logic [7:0] TSF_IDX_IRQEN   = 8'hF4;
    localparam logic [7:0] TSF_IDX_IRQCLR  = 8'hF5;

    localparam logic [1:0] TSF_LANE = 2'h0;
    localparam logic [1:0] TSF_PAD  = 2'h0;

    localparam int unsigned TSF_B_TEMPCLR = 7;
    localparam int unsigned TSF_B_RFOK    = 5;
    localparam int unsigned TSF_B_TGT     = 4;
    localparam int unsigned TSF_B_CIPHER  = 3;
    localparam int unsigned TSF_B_FLUSH   = 7;
    localparam int unsigned TSF_B_TXWRF   = 0;
    localparam int unsigned TSF_B_RXWRF   = 1;

    localparam int unsigned TSF_IRQ_TGT    = 0;
    localparam int unsigned TSF_IRQ_CIPHER = 1;
    localparam int unsigned TSF_IRQ_OVFL   = 2;
    localparam int unsigned TSF_IRQ_TEMP   = 3;
    localparam int unsigned TSF_NIRQ       = 4;

    localparam logic [7:0]  TSF_RST_BYTE  = 8'h00;
    localparam logic [31:0] TSF_RST_WORD  = 32'h0000_0000;

    localparam logic [15:0] TSF_FREQ_LO_KHZ = 16'h2EE0;
    localparam logic [15:0] TSF_FREQ_HI_KHZ = 16'h3A98;

    localparam logic [2:0] TSF_ST_IDLE     = 3'h0;
    localparam logic [2:0] TSF_ST_WLAUNCH  = 3'h1;
    localparam logic [2:0] TSF_ST_TX_GUARD_TIME   = 3'h2;
    localparam logic [2:0] TSF_ST_TX       = 3'h3;
    localparam logic [2:0] TSF_ST_RX_GUARD_TIME   = 3'h4;
    localparam logic [2:0] TSF_ST_WDATA    = 3'h5;
    localparam logic [2:0] TSF_ST_RX       = 3'h6;

    localparam logic [1:0] TSF_PH_ISSUE = 2'h0;
    localparam logic [1:0] TSF_PH_ANS   = 2'h1;
endpackage

// ### verilog/tsf_byte_mem.sv
// Purpose: byte storage of the queue, registered read port
// Assumes: one write and one read port, no reset of contents
// Notes: contents undefined after reset
`timescale 1ns/1ns
module tsf_byte_mem #(
    parameter int unsigned DEPTH = 64,
    parameter int unsigned AW    = 6
) (
    input  wire logic          core_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data_q
);
    import tsf_pkg::*;
    logic [7:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule // tsf_byte_mem

// ### verilog/tsf_xcvr_fsm.sv
// Purpose: transmit/receive sequencing and its 3-bit state code
// Assumes: guard times counted in core_clk cycles
// Notes: dropping transceive_on returns to idle from any state
`timescale 1ns/1ns
module tsf_xcvr_fsm #(
    parameter int unsigned GW = 8
) (
    input  wire logic          core_clk,
    input  wire logic          sys_rst,
    input  wire logic          transceive_on,
    input  wire logic          launch_transmit,
    input  wire logic          rf_field_on,
    input  wire logic          tx_wait_for_field,
    input  wire logic          rx_wait_for_field,
    input  wire logic [GW-1:0] tx_guard_time,
    input  wire logic [GW-1:0] rx_guard_time,
    input  wire logic          tx_done,
    input  wire logic          rx_data_seen,
    input  wire logic          rx_done,
    output logic      [2:0]    transceiver_state
);
    import tsf_pkg::*;
    typedef enum logic [2:0] {S_IDLE, S_WLAUNCH, S_TX_GUARD_TIME, S_TX,
                              S_RX_GUARD_TIME, S_WDATA, S_RX} tsf_xst_t;
    typedef struct packed {
        tsf_xst_t        st;
        logic [GW-1:0]   cnt;
        logic [2:0]      code;
    } tsf_xfsm_t;
    tsf_xfsm_t q, d;

    always_comb begin
        d = q;
        d.cnt = (q.cnt == '1) ? q.cnt : q.cnt + 1'b1;
        case (q.st)
            S_IDLE: begin
                if (transceive_on) d.st = S_WLAUNCH;
            end
            S_WLAUNCH: begin
                if (launch_transmit) begin
                    d.st = S_TX_GUARD_TIME;
                    d.cnt = '0;
                end
            end
            S_TX_GUARD_TIME: begin
                if (q.cnt >= tx_guard_time && (!tx_wait_for_field || rf_field_on)) begin
                    d.st = S_TX;
                end
            end
            S_TX: begin
                if (tx_done) begin
                    d.st = S_RX_GUARD_TIME;
                    d.cnt = '0;
                end
            end
            S_RX_GUARD_TIME: begin
                if (q.cnt >= rx_guard_time && (!rx_wait_for_field || rf_field_on)) begin
                    d.st = S_WDATA;
                end
            end
            S_WDATA: begin
                if (rx_data_seen) d.st = S_RX;
            end
            S_RX: begin
                if (rx_done) d.st = S_WLAUNCH;
            end
            default: d.st = S_IDLE;
        endcase
        if (!transceive_on) d.st = S_IDLE;
        case (d.st)
            S_IDLE:    d.code = TSF_ST_IDLE;
            S_WLAUNCH: d.code = TSF_ST_WLAUNCH;
            S_TX_GUARD_TIME:  d.code = TSF_ST_TX_GUARD_TIME;
            S_TX:      d.code = TSF_ST_TX;
            S_RX_GUARD_TIME:  d.code = TSF_ST_RX_GUARD_TIME;
            S_WDATA:   d.code = TSF_ST_WDATA;
            S_RX:      d.code = TSF_ST_RX;
            default:   d.code = TSF_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= '{st: S_IDLE, cnt: '0, code: TSF_ST_IDLE};
        end else begin
            q <= d;
        end
    end

    assign transceiver_state = q.code;
endmodule // tsf_xcvr_fsm

// ### verilog/tsf_regs.sv
// Purpose: status, byte queue port and fill level registers on APB
// Assumes: byte address = register index * 4, data in bits 7:0
// Notes: every access answers in its third access cycle
// Operation
// - temp alarm clear write clears latched error only below alarm limit
// - rf frequency flag is one when frequency strictly between 12 and 15 MHz
// - rf frequency flag undefined in 9-12 MHz and just above 15 MHz
// - target flag sets on error-free select or once it was answered
// - target flag sets only during anticollision in passive or card modes
// - target flag clears when the rf field switches off
// - cipher flag reads one while card cipher unit is on
// - cipher flag set only by successful card auth in reader mode
// - 3-bit state field: 000 idle, 011 tx, 101 wait data, 110 rx
// - state 001 while waiting for the launch transmit bit
// - state 010 tx wait, holds for field if enabled, lasts guard time
// - state 100 rx wait, holds for field if enabled, lasts guard time
// - 8-bit data port: write pushes, read pops a 64-byte queue
// - queue buffers all transmit and receive byte streams
// - 7-bit fill count in level register bits 6:0, resets to zero
// - flush bit clears pointers and overflow flag, reads zero
// - port write increments, port read decrements the fill count
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module tsf_regs #(
    parameter int unsigned DEPTH = tsf_pkg::TSF_DEPTH,
    parameter int unsigned GW    = tsf_pkg::TSF_GW
) (
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [tsf_pkg::TSF_AW-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic                           irq,
    input  wire logic                      temp_over_limit,
    input  wire logic                      temp_alarm_event,
    output logic                           temp_error,
    input  wire logic [15:0]               rf_freq_khz,
    input  wire logic                      rf_field_on,
    input  wire logic                      select_ok,
    input  wire logic                      select_answered,
    input  wire logic                      auto_anticollision_cmd,
    input  wire logic                      passive_or_card_mode,
    input  wire logic                      card_auth_cmd_ok,
    input  wire logic                      reader_mode,
    input  wire logic                      transceive_on,
    input  wire logic                      launch_transmit,
    input  wire logic                      tx_done,
    input  wire logic                      rx_data_seen,
    input  wire logic                      rx_done,
    output logic      [2:0]                transceiver_state,
    input  wire logic                      stream_push,
    input  wire logic [7:0]                stream_push_data,
    output logic                           stream_ready,
    input  wire logic                      stream_pop,
    output logic                           stream_pop_valid,
    output logic      [7:0]                stream_pop_data,
    output logic                           queue_overflow_flag
);
    import tsf_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = AW + 1;

    if (DEPTH < 2 || DEPTH > 64 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two from 2 to 64");
    end
    if (GW < 1 || GW > 8) begin : g_bad_gw
        $error("GW must be 1 to 8");
    end

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic [1:0]        ph;
        logic              temp_clr;
        logic              temp_err;
        logic              rf_ok;
        logic              tgt;
        logic              cipher;
        logic              rf_prev;
        logic [AW-1:0]     wptr;
        logic [AW-1:0]     rptr;
        logic [CW-1:0]     cnt;
        logic              ovfl;
        logic [1:0]        ctrl;
        logic [GW-1:0]     txg;
        logic [GW-1:0]     rxg;
        logic [TSF_NIRQ-1:0] sts;
        logic [TSF_NIRQ-1:0] ien;
        logic              irq;
        logic              s_ready;
        logic              s_valid;
    } tsf_regs_state_t;

    tsf_regs_state_t q, d;

    logic [7:0]    idx;
    logic          hit_ok;
    logic          access;
    logic          commit;
    logic          wr_c;
    logic          rd_c;
    logic          apb_push;
    logic          apb_pop;
    logic          s_push;
    logic          s_pop;
    logic          mem_we;
    logic [7:0]    mem_wdata;
    logic          mem_re;
    logic [AW-1:0] mem_raddr;
    logic [7:0]    mem_rdata;
    logic          flush;
    logic [TSF_NIRQ-1:0] ev;
    logic [7:0]    rdv;
    logic          full;
    logic          push;
    logic          pop;

    always_comb begin
        idx       = paddr[9:2];
        hit_ok    = (paddr[1:0] == TSF_PAD) && (paddr[TSF_AW-1:10] == '0) &&
                    (idx inside {TSF_IDX_STATUS2, TSF_IDX_DATA, TSF_IDX_LEVEL,
                                 TSF_IDX_CTRL, TSF_IDX_TXGUARD, TSF_IDX_RXGUARD,
                                 TSF_IDX_IRQSTS, TSF_IDX_IRQEN, TSF_IDX_IRQCLR});
        access    = psel && penable;
        commit    = access && q.pready;
        wr_c      = commit && pwrite && hit_ok;
        rd_c      = commit && !pwrite && hit_ok;
        full      = (q.cnt == CW'(DEPTH));
        apb_push  = wr_c && (idx == TSF_IDX_DATA);
        apb_pop   = rd_c && (idx == TSF_IDX_DATA) && (q.cnt != '0);
        s_push    = stream_push && q.s_ready;
        s_pop     = stream_pop && q.s_ready && (q.cnt != '0);
        flush     = wr_c && (idx == TSF_IDX_LEVEL) && pwdata[TSF_B_FLUSH];
        push      = (apb_push || s_push) && !full;
        pop       = apb_pop || s_pop;
        mem_we    = push && !flush;
        mem_wdata = apb_push ? pwdata[7:0] : stream_push_data;
        mem_re    = s_pop || (access && !q.pready && q.ph == TSF_PH_ISSUE &&
                              !pwrite && idx == TSF_IDX_DATA);
        mem_raddr = q.rptr;
    end

    always_comb begin
        rdv = TSF_RST_BYTE;
        case (idx)
            TSF_IDX_STATUS2: begin
                rdv[TSF_B_TEMPCLR] = q.temp_clr;
                rdv[TSF_B_RFOK]    = q.rf_ok;
                rdv[TSF_B_TGT]     = q.tgt;
                rdv[TSF_B_CIPHER]  = q.cipher;
                rdv[2:0]           = transceiver_state;
            end
            TSF_IDX_DATA:    rdv = (q.cnt != '0) ? mem_rdata : TSF_RST_BYTE;
            TSF_IDX_LEVEL:   rdv = 8'(q.cnt);
            TSF_IDX_CTRL:    rdv = 8'(q.ctrl);
            TSF_IDX_TXGUARD: rdv = 8'(q.txg);
            TSF_IDX_RXGUARD: rdv = 8'(q.rxg);
            TSF_IDX_IRQSTS:  rdv = 8'(q.sts);
            TSF_IDX_IRQEN:   rdv = 8'(q.ien);
            default:         rdv = TSF_RST_BYTE;
        endcase
    end

    always_comb begin
        d  = q;
        ev = '0;

        // apb answer sequencing
        if (access && !q.pready) begin
            d.ph = q.ph + 2'h1;
            if (q.ph == TSF_PH_ANS) begin
                d.pready  = 1'b1;
                d.pslverr = !hit_ok;
                d.prdata  = (pwrite || !hit_ok) ? TSF_RST_WORD : 32'(rdv);
            end
        end
        if (commit || !psel) begin
            d.pready  = 1'b0;
            d.pslverr = 1'b0;
            d.ph      = TSF_PH_ISSUE;
        end
        d.s_ready = !psel;
        d.s_valid = s_pop;

        // rf frequency window
        d.rf_ok   = (rf_freq_khz > TSF_FREQ_LO_KHZ) &&
                    (rf_freq_khz < TSF_FREQ_HI_KHZ);
        d.rf_prev = rf_field_on;

        // temperature alarm
        if (wr_c && idx == TSF_IDX_STATUS2) begin
            d.temp_clr = pwdata[TSF_B_TEMPCLR];
            if (pwdata[TSF_B_TEMPCLR] && !temp_over_limit) begin
                d.temp_err = 1'b0;
            end
        end
        if (temp_alarm_event) begin
            d.temp_err = 1'b1;
            ev[TSF_IRQ_TEMP] = !q.temp_err;
        end

        // target activation
        if (q.rf_prev && !rf_field_on) begin
            d.tgt = 1'b0;
        end
        if ((select_ok || select_answered) && auto_anticollision_cmd &&
            passive_or_card_mode) begin
            d.tgt = 1'b1;
            ev[TSF_IRQ_TGT] = !q.tgt;
        end

        // cipher flag, cleared only by software
        if (wr_c && idx == TSF_IDX_STATUS2 && !pwdata[TSF_B_CIPHER]) begin
            d.cipher = 1'b0;
        end
        if (card_auth_cmd_ok && reader_mode) begin
            d.cipher = 1'b1;
            ev[TSF_IRQ_CIPHER] = !q.cipher;
        end

        // queue pointers and fill count
        if (push) begin
            d.wptr = q.wptr + 1'b1;
        end
        if (pop) begin
            d.rptr = q.rptr + 1'b1;
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
        if ((apb_push || s_push) && full) begin
            d.ovfl = 1'b1;
            ev[TSF_IRQ_OVFL] = !q.ovfl;
        end
        if (flush) begin
            d.wptr = '0;
            d.rptr = '0;
            d.cnt  = '0;
            d.ovfl = 1'b0;
        end

        // local control and guard registers
        if (wr_c && idx == TSF_IDX_CTRL) begin
            d.ctrl = pwdata[1:0];
        end
        if (wr_c && idx == TSF_IDX_TXGUARD) begin
            d.txg = pwdata[GW-1:0];
        end
        if (wr_c && idx == TSF_IDX_RXGUARD) begin
            d.rxg = pwdata[GW-1:0];
        end
        if (wr_c && idx == TSF_IDX_IRQEN) begin
            d.ien = pwdata[TSF_NIRQ-1:0];
        end

        // sticky events, set wins over clear
        if (wr_c && idx == TSF_IDX_IRQCLR) begin
            d.sts = q.sts & ~pwdata[TSF_NIRQ-1:0];
        end
        d.sts = d.sts | ev;
        d.irq = |(d.sts & d.ien);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.prdata <= TSF_RST_WORD;
        end else begin
            q <= d;
        end
    end

    tsf_byte_mem #(
        .DEPTH     (DEPTH),
        .AW        (AW)
    ) u_mem (
        .core_clk  (core_clk),
        .wr_en     (mem_we),
        .wr_addr   (q.wptr),
        .wr_data   (mem_wdata),
        .rd_en     (mem_re),
        .rd_addr   (mem_raddr),
        .rd_data_q (mem_rdata)
    );

    tsf_xcvr_fsm #(
        .GW                (GW)
    ) u_fsm (
        .core_clk          (core_clk),
        .sys_rst           (sys_rst),
        .transceive_on     (transceive_on),
        .launch_transmit   (launch_transmit),
        .rf_field_on       (rf_field_on),
        .tx_wait_for_field (q.ctrl[TSF_B_TXWRF]),
        .rx_wait_for_field (q.ctrl[TSF_B_RXWRF]),
        .tx_guard_time     (q.txg),
        .rx_guard_time     (q.rxg),
        .tx_done           (tx_done),
        .rx_data_seen      (rx_data_seen),
        .rx_done           (rx_done),
        .transceiver_state (transceiver_state)
    );

    assign prdata              = q.prdata;
    assign pready              = q.pready;
    assign pslverr             = q.pslverr;
    assign irq                 = q.irq;
    assign temp_error          = q.temp_err;
    assign stream_ready        = q.s_ready;
    assign stream_pop_valid    = q.s_valid;
    assign stream_pop_data     = mem_rdata;
    assign queue_overflow_flag = q.ovfl;
endmodule // tsf_regs

// ### dv/tsf_regs_properties.sv
// Purpose: concurrent checks on the status and byte queue register ports
// Assumes: byte address is index times four, state shows one cycle after cause
// Notes: bound to tsf_regs after the module
`timescale 1ns/1ns
module tsf_props (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        temp_over_limit,
    input wire logic        temp_alarm_event,
    input wire logic        temp_error,
    input wire logic        transceive_on,
    input wire logic        launch_transmit,
    input wire logic [2:0]  transceiver_state,
    input wire logic        stream_pop,
    input wire logic        stream_ready,
    input wire logic        stream_pop_valid,
    input wire logic        queue_overflow_flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    apb_answer_a: assert property (psel && !penable |=> !pready ##1 !pready ##1 pready)
        else $error("apb answer not in third access cycle");
    level_read_a: assert property (pready && !pwrite && paddr == 12'h3AC |->
        prdata[31:7] == 25'h0 && prdata[6:0] <= 7'h40)
        else $error("level read out of range");
    flush_ovfl_a: assert property (pready && pwrite && paddr == 12'h3AC && pwdata[7]
        |=> !queue_overflow_flag) else $error("flush left overflow set");
    temp_clear_a: assert property (pready && pwrite && paddr == 12'h3A4 && pwdata[7]
        && !temp_over_limit && !temp_alarm_event |=> !temp_error)
        else $error("temperature error not cleared");
    temp_hold_a: assert property (pready && pwrite && paddr == 12'h3A4 && temp_error
        && temp_over_limit |=> temp_error) else $error("temperature error cleared when hot");
    off_idle_a: assert property (!transceive_on |=> transceiver_state == 3'h0)
        else $error("state not idle");
    arm_wait_a: assert property (transceiver_state == 3'h0 && transceive_on
        |=> transceiver_state == 3'h1) else $error("no wait for launch");
    launch_go_a: assert property (transceiver_state == 3'h1 && transceive_on |=>
        transceiver_state == ($past(launch_transmit) ? 3'h2 : 3'h1))
        else $error("launch step wrong");
    pop_valid_a: assert property (stream_pop_valid |-> $past(stream_pop && stream_ready))
        else $error("pop valid without pop");
    cover property (pready && pwrite && paddr == 12'h3AC && pwdata[7]);
    cover property (transceiver_state == 3'h6);
    cover property (stream_pop_valid);
endmodule // tsf_props
bind tsf_regs tsf_props u_props (.*);

// ### dv/transceiver_status_fifo_regs_tb.sv
// Purpose: self-checking bench for the status and byte queue registers
// Assumes: apb master with pready handshake, fixed seed random stimulus
// Notes: expectations from bench functions and a byte queue model
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module transceiver_status_fifo_regs_tb;
    import tsf_pkg::*;
    logic        core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic [15:0] rf_freq_khz = 16'h0;
    logic [7:0]  stream_push_data = 8'h0, stream_pop_data, b, q[$];
    logic [2:0]  transceiver_state;
    logic        temp_over_limit = 1'b0, temp_alarm_event = 1'b0, rf_field_on = 1'b0;
    logic        select_ok = 1'b0, select_answered = 1'b0, auto_anticollision_cmd = 1'b0;
    logic        passive_or_card_mode = 1'b0, card_auth_cmd_ok = 1'b0, reader_mode = 1'b0;
    logic        transceive_on = 1'b0, launch_transmit = 1'b0, tx_done = 1'b0;
    logic        rx_data_seen = 1'b0, rx_done = 1'b0, stream_push = 1'b0, stream_pop = 1'b0;
    logic        pready, pslverr, irq, temp_error, stream_ready, stream_pop_valid, er;
    logic        queue_overflow_flag;
    int          failures = 0, checks_done = 0, cyc = 0, n, k;

    tsf_regs DUT (.*);
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            close_out();
        end
    end

    function automatic logic freq_ok(input logic [15:0] khz);
        return khz > TSF_FREQ_LO_KHZ && khz < TSF_FREQ_HI_KHZ;
    endfunction
    function automatic logic [7:0] lvl();
        return 8'(q.size());
    endfunction
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        v = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rchk(input logic [7:0] idx, m, e, input string nm);
        apb(1'b0, idx, 8'h00);
        `CHK(nm, e, v[7:0] & m)
    endtask
    task automatic wait_st(input logic [2:0] s);
        n = 0;
        while (transceiver_state !== s && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        `CHK("state", s, transceiver_state)
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h99C1));
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rchk(TSF_IDX_STATUS2, 8'hFF, 8'h00, "status2 reset");
        rchk(TSF_IDX_LEVEL, 8'hFF, 8'h00, "level reset");
        apb(1'b0, 8'hE0, 8'h00);
        `CHK("unmapped error", 1'b1, er)
        n = $urandom_range(20, 5);
        for (k = 0; k < n; k++) begin
            b = 8'($urandom);
            q.push_back(b);
            wr(TSF_IDX_DATA, b);
        end
        repeat (3) begin
            b = 8'($urandom);
            q.push_back(b);
            stream_push <= 1'b1;
            stream_push_data <= b;
            @(posedge core_clk);
        end
        stream_push <= 1'b0;
        rchk(TSF_IDX_LEVEL, 8'h7F, lvl(), "fill count");
        stream_pop <= 1'b1;
        @(posedge core_clk);
        `CHK("stream ready", 1'b1, stream_ready)
        stream_pop <= 1'b0;
        @(posedge core_clk);
        b = q.pop_front();
        `CHK("pop valid", 1'b1, stream_pop_valid)
        `CHK("pop data", b, stream_pop_data)
        while (q.size() > 0) rchk(TSF_IDX_DATA, 8'hFF, q.pop_front(), "port byte");
        rchk(TSF_IDX_DATA, 8'hFF, 8'h00, "empty read");
        rchk(TSF_IDX_LEVEL, 8'hFF, 8'h00, "drained");
        wr(TSF_IDX_IRQEN, 8'h00);
        repeat (TSF_DEPTH + 1) wr(TSF_IDX_DATA, 8'($urandom));
        repeat (2) @(posedge core_clk);
        `CHK("overflow", 1'b1, queue_overflow_flag)
        `CHK("irq masked", 1'b0, irq)
        rchk(TSF_IDX_LEVEL, 8'hFF, 8'h40, "full count");
        rchk(TSF_IDX_IRQSTS, 8'h04, 8'h04, "irq status");
        wr(TSF_IDX_IRQEN, 8'h04);
        repeat (2) @(posedge core_clk);
        `CHK("irq on", 1'b1, irq)
        wr(TSF_IDX_IRQCLR, 8'h04);
        repeat (2) @(posedge core_clk);
        `CHK("irq cleared", 1'b0, irq)
        wr(TSF_IDX_LEVEL, 8'h80);
        `CHK("flush overflow", 1'b0, queue_overflow_flag)
        rchk(TSF_IDX_LEVEL, 8'hFF, 8'h00, "flushed");
        for (k = 0; k < 8; k++) begin
            if (k < 2) rf_freq_khz <= (k == 0) ? 16'd12001 : 16'd14999;
            else if (k % 2 == 1) rf_freq_khz <= 16'($urandom_range(8999, 0));
            else rf_freq_khz <= 16'($urandom_range(40000, 20000));
            @(posedge core_clk);
            rchk(TSF_IDX_STATUS2, 8'h20, {2'h0, freq_ok(rf_freq_khz), 5'h0}, "rf");
        end
        rf_field_on <= 1'b1;
        select_answered <= 1'b1;
        @(posedge core_clk);
        select_answered <= 1'b0;
        rchk(TSF_IDX_STATUS2, 8'h10, 8'h00, "target idle");
        auto_anticollision_cmd <= 1'b1;
        passive_or_card_mode <= 1'b1;
        select_ok <= 1'b1;
        @(posedge core_clk);
        select_ok <= 1'b0;
        rchk(TSF_IDX_STATUS2, 8'h10, 8'h10, "target set");
        rf_field_on <= 1'b0;
        @(posedge core_clk);
        rchk(TSF_IDX_STATUS2, 8'h10, 8'h00, "target off");
        card_auth_cmd_ok <= 1'b1;
        @(posedge core_clk);
        card_auth_cmd_ok <= 1'b0;
        rchk(TSF_IDX_STATUS2, 8'h08, 8'h00, "cipher card");
        reader_mode <= 1'b1;
        card_auth_cmd_ok <= 1'b1;
        @(posedge core_clk);
        card_auth_cmd_ok <= 1'b0;
        rchk(TSF_IDX_STATUS2, 8'h08, 8'h08, "cipher on");
        wr(TSF_IDX_STATUS2, 8'h00);
        rchk(TSF_IDX_STATUS2, 8'h08, 8'h00, "cipher off");
        temp_alarm_event <= 1'b1;
        temp_over_limit <= 1'b1;
        @(posedge core_clk);
        temp_alarm_event <= 1'b0;
        wr(TSF_IDX_STATUS2, 8'h80);
        `CHK("temp hot", 1'b1, temp_error)
        temp_over_limit <= 1'b0;
        wr(TSF_IDX_STATUS2, 8'h80);
        `CHK("temp cool", 1'b0, temp_error)
        wr(TSF_IDX_TXGUARD, 8'h04);
        wr(TSF_IDX_RXGUARD, 8'h03);
        wr(TSF_IDX_CTRL, 8'h03);
        transceive_on <= 1'b1;
        wait_st(TSF_ST_WLAUNCH);
        launch_transmit <= 1'b1;
        @(posedge core_clk);
        launch_transmit <= 1'b0;
        repeat (10) @(posedge core_clk);
        `CHK("tx field hold", TSF_ST_TX_GUARD_TIME, transceiver_state)
        rf_field_on <= 1'b1;
        wait_st(TSF_ST_TX);
        tx_done <= 1'b1;
        @(posedge core_clk);
        tx_done <= 1'b0;
        wait_st(TSF_ST_RX_GUARD_TIME);
        wait_st(TSF_ST_WDATA);
        `CHK("rx guard", 1'b1, n >= 3)
        rx_data_seen <= 1'b1;
        @(posedge core_clk);
        rx_data_seen <= 1'b0;
        wait_st(TSF_ST_RX);
        rx_done <= 1'b1;
        @(posedge core_clk);
        rx_done <= 1'b0;
        wait_st(TSF_ST_WLAUNCH);
        launch_transmit <= 1'b1;
        @(posedge core_clk);
        launch_transmit <= 1'b0;
        wait_st(TSF_ST_TX_GUARD_TIME);
        wait_st(TSF_ST_TX);
        `CHK("tx guard", 1'b1, n >= 4)
        transceive_on <= 1'b0;
        wait_st(TSF_ST_IDLE);
        close_out();
    end
endmodule // transceiver_status_fifo_regs_tb
